// >>> hw/fcs_decoder.sv
// command sequence decoder for the flash write-cycle command set
`timescale 1ns/10ps
module fcs_decoder
  import fcs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                linkClk,
  input  wire logic                linkReset_n,
  input  wire logic                cycleValid,
  input  wire fcs_pkg::fcs_cycle_t cycleIn,
  output logic                     cycleReady,
  output logic [15:0]              rdData,
  output logic                     rdValid,
  input  wire logic [15:0]         arrayRdData,
  input  wire logic [15:0]         statusSet,
  output fcs_pkg::fcs_cmd_t        cmd,
  output logic                     cmdValid,
  output fcs_pkg::fcs_space_t      overlaySpace,
  output logic                     bufActive,
  output logic [15:0]              resetPulseLength,
  output logic [15:0]              interruptConfig,
  output logic [15:0]              interruptFlags,
  output logic [15:0]              volatileConfig,
  output logic [15:0]              persistentConfig,
  output logic [15:0]              statusValue
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_UNLK1, ST_UNLK2, ST_LOAD, ST_ERS1, ST_ERS2, ST_ERS3,
    ST_WPROG, ST_BUFCNT, ST_BUFDATA, ST_BUFCONF
  } fcs_state_t;

  typedef enum logic [2:0] {
    SRC_ARRAY, SRC_STATUS, SRC_RPL, SRC_ICFG, SRC_IFLAG, SRC_VCFG, SRC_PCFG
  } fcs_src_t;

  function automatic logic atAddr(input logic [ADDR_W-1:0] a, input logic [11:0] v);
    atAddr = a[11:0] == v;
  endfunction

  fcs_cycle_t  heldCycle;
  logic        reqTgl;
  logic        reqMeta_reg, reqSync_reg, reqSeen_reg, reqSeen_next;
  logic        ack_reg, ack_next;
  logic [15:0] rd_reg, rd_next;
  logic        newCycle;

  fcs_state_t  state_reg, state_next;
  fcs_src_t    src_reg, src_next;
  fcs_src_t    load_reg, load_next;
  fcs_space_t  space_reg, space_next;
  logic        buf_reg, buf_next;
  logic [ADDR_W-SECT_LSB-1:0] sect_reg, sect_next;
  logic [WC_W-1:0] left_reg, left_next;
  fcs_cmd_t    cmd_reg, cmd_next;
  logic        cmdv_reg, cmdv_next;
  logic [15:0] stat_reg, stat_next;
  logic [15:0] rpl_reg, rpl_next;
  logic [15:0] icfg_reg, icfg_next;
  logic [15:0] iflag_reg, iflag_next;
  logic [15:0] vcfg_reg, vcfg_next;
  logic [15:0] pcfg_reg, pcfg_next;

  fcs_link u_link (
    .linkClk     (linkClk),
    .linkReset_n (linkReset_n),
    .cycleValid  (cycleValid),
    .cycleIn     (cycleIn),
    .cycleReady  (cycleReady),
    .rdData      (rdData),
    .rdValid     (rdValid),
    .heldCycle   (heldCycle),
    .reqTgl      (reqTgl),
    .ackTgl      (ack_reg),
    .coreRdData  (rd_reg)
  );

  // held cycle is stable while the request toggle is in flight
  assign newCycle = reqSync_reg != reqSeen_reg;

  always_comb
  begin
    logic [ADDR_W-1:0] a;
    logic [7:0]        d;
    logic              sameSect;
    a            = heldCycle.addr;
    d            = heldCycle.data[7:0];
    sameSect     = a[ADDR_W-1:SECT_LSB] == sect_reg;
    reqSeen_next = reqSeen_reg;
    ack_next     = ack_reg;
    rd_next      = rd_reg;
    state_next   = state_reg;
    src_next     = src_reg;
    load_next    = load_reg;
    space_next   = space_reg;
    buf_next     = buf_reg;
    sect_next    = sect_reg;
    left_next    = left_reg;
    cmd_next     = cmd_reg;
    cmdv_next    = 1'b0;
    // a status event in the clearing cycle survives the clear
    stat_next    = stat_reg | statusSet;
    rpl_next     = rpl_reg;
    icfg_next    = icfg_reg;
    iflag_next   = iflag_reg;
    vcfg_next    = vcfg_reg;
    pcfg_next    = pcfg_reg;

    if (newCycle)
    begin
      reqSeen_next = reqSync_reg;
      ack_next     = !ack_reg;
      cmd_next.addr = a;
      cmd_next.data = heldCycle.data;
      if (!heldCycle.write)
      begin
        case (src_reg)
          SRC_STATUS: rd_next = stat_reg;
          SRC_RPL:    rd_next = rpl_reg;
          SRC_ICFG:   rd_next = icfg_reg;
          SRC_IFLAG:  rd_next = iflag_reg;
          SRC_VCFG:   rd_next = vcfg_reg;
          SRC_PCFG:   rd_next = pcfg_reg;
          default:    rd_next = arrayRdData;
        endcase
        src_next = SRC_ARRAY;
      end
      else if (d == OPC_RESET || (d == OPC_RESET_ALT && space_reg == SPC_ID))
      begin
        state_next = ST_IDLE;
        space_next = SPC_ARRAY;
        src_next   = SRC_ARRAY;
        if (buf_reg)
        begin
          buf_next     = 1'b0;
          cmd_next.op  = OP_BUF_ABORT;
          cmdv_next    = 1'b1;
        end
      end
      else
      begin
        state_next = ST_IDLE;
        case (state_reg)
          ST_IDLE:
          begin
            if (d == OPC_UNLOCK1 && atAddr(a, ADDR_UNLOCK1))
              state_next = ST_UNLK1;
            else if (d == OPC_STAT_READ && atAddr(a, ADDR_UNLOCK1))
              src_next = SRC_STATUS;
            else if (d == OPC_STAT_CLEAR && atAddr(a, ADDR_UNLOCK1))
              stat_next = statusSet;
            else if (d == OPC_QUERY_ENT && atAddr(a, ADDR_UNLOCK1))
              space_next = SPC_QUERY;
            else
            begin
              cmdv_next = 1'b1;
              case (d)
                OPC_BLANK_CHK:  cmd_next.op = OP_BLANK_CHK;
                OPC_EVAL_ERASE: cmd_next.op = OP_EVAL_ERASE;
                OPC_ERASE_SUSP: cmd_next.op = OP_ERASE_SUSP;
                OPC_ERASE_RES:  cmd_next.op = OP_ERASE_RES;
                OPC_PROG_SUSP:  cmd_next.op = OP_PROG_SUSP;
                OPC_PROG_RES:   cmd_next.op = OP_PROG_RES;
                default:        cmdv_next = 1'b0;
              endcase
            end
          end
          ST_UNLK1:
            if (d == OPC_UNLOCK2 && atAddr(a, ADDR_UNLOCK2))
              state_next = ST_UNLK2;
          ST_UNLK2:
          begin
            if (d == OPC_BUF_WRITE)
            begin
              sect_next  = a[ADDR_W-1:SECT_LSB];
              buf_next   = 1'b1;
              state_next = ST_BUFCNT;
            end
            else if (d == OPC_DEEP_PD)
            begin
              cmd_next.op = OP_DEEP_PD;
              cmdv_next   = 1'b1;
            end
            else if (atAddr(a, ADDR_UNLOCK1))
            begin
              case (d)
                OPC_RPL_LOAD:   begin load_next = SRC_RPL;   state_next = ST_LOAD; end
                OPC_RPL_READ:   src_next = SRC_RPL;
                OPC_ICFG_LOAD:  begin load_next = SRC_ICFG;  state_next = ST_LOAD; end
                OPC_ICFG_READ:  src_next = SRC_ICFG;
                OPC_IFLAG_LOAD: begin load_next = SRC_IFLAG; state_next = ST_LOAD; end
                OPC_IFLAG_READ: src_next = SRC_IFLAG;
                OPC_VCFG_LOAD:  begin load_next = SRC_VCFG;  state_next = ST_LOAD; end
                OPC_VCFG_READ:  src_next = SRC_VCFG;
                OPC_PCFG_PROG:  begin load_next = SRC_PCFG;  state_next = ST_LOAD; end
                OPC_PCFG_READ:  src_next = SRC_PCFG;
                OPC_PCFG_ERASE:
                begin
                  pcfg_next   = ERASED_PCFG;
                  cmd_next.op = OP_PCFG_ERASE;
                  cmdv_next   = 1'b1;
                end
                OPC_WORD_PROG:  state_next = ST_WPROG;
                OPC_ERASE_SET:  state_next = ST_ERS1;
                OPC_ID_ENTRY:   space_next = SPC_ID;
                OPC_OTP_ENTRY:  space_next = SPC_OTP;
                default:        state_next = ST_IDLE;
              endcase
            end
          end
          ST_LOAD:
          begin
            case (load_reg)
              SRC_RPL:   rpl_next   = heldCycle.data;
              SRC_ICFG:  icfg_next  = heldCycle.data;
              SRC_IFLAG: iflag_next = heldCycle.data;
              SRC_VCFG:  vcfg_next  = heldCycle.data;
              SRC_PCFG:
              begin
                pcfg_next   = heldCycle.data;
                cmd_next.op = OP_PCFG_PROG;
                cmdv_next   = 1'b1;
              end
              default:   rpl_next   = rpl_reg;
            endcase
          end
          ST_ERS1:
            if (d == OPC_UNLOCK1 && atAddr(a, ADDR_UNLOCK1))
              state_next = ST_ERS2;
          ST_ERS2:
            if (d == OPC_UNLOCK2 && atAddr(a, ADDR_UNLOCK2))
              state_next = ST_ERS3;
          ST_ERS3:
          begin
            if (d == OPC_CHIP_ERASE && atAddr(a, ADDR_UNLOCK1))
            begin
              cmd_next.op = OP_CHIP_ERASE;
              cmdv_next   = 1'b1;
            end
            else if (d == OPC_SECT_ERASE)
            begin
              cmd_next.op = OP_SECT_ERASE;
              cmdv_next   = 1'b1;
            end
          end
          ST_WPROG:
          begin
            cmd_next.op = OP_WORD_PROG;
            cmdv_next   = 1'b1;
          end
          ST_BUFCNT:
          begin
            state_next = ST_BUFCNT;
            if (sameSect)
            begin
              left_next  = heldCycle.data[WC_W-1:0];
              state_next = ST_BUFDATA;
            end
          end
          ST_BUFDATA:
          begin
            cmd_next.op = OP_BUF_LOAD;
            cmdv_next   = 1'b1;
            left_next   = left_reg - 1'b1;
            state_next  = (left_reg == '0) ? ST_BUFCONF : ST_BUFDATA;
          end
          ST_BUFCONF:
          begin
            // an unlock here restarts the unlock sequence; the buffer stays loaded until a reset opcode
            state_next = ST_BUFCONF;
            if (d == OPC_BUF_COMMIT && sameSect)
            begin
              cmd_next.op = OP_BUF_COMMIT;
              cmdv_next   = 1'b1;
              buf_next    = 1'b0;
              state_next  = ST_IDLE;
            end
            else if (d == OPC_UNLOCK1 && atAddr(a, ADDR_UNLOCK1))
              state_next = ST_UNLK1;
          end
          default:
            state_next = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      reqSeen_reg <= 1'b0;
      ack_reg     <= 1'b0;
      rd_reg      <= 16'h0000;
      state_reg   <= ST_IDLE;
      src_reg     <= SRC_ARRAY;
      load_reg    <= SRC_ARRAY;
      space_reg   <= SPC_ARRAY;
      buf_reg     <= 1'b0;
      sect_reg    <= '0;
      left_reg    <= '0;
      cmd_reg     <= '0;
      cmdv_reg    <= 1'b0;
      stat_reg    <= RST_STATUS;
      rpl_reg     <= RST_RPL;
      icfg_reg    <= RST_ICFG;
      iflag_reg   <= RST_IFLAG;
      vcfg_reg    <= RST_VCFG;
      pcfg_reg    <= RST_PCFG;
    end
    else
    begin
      reqMeta_reg <= reqTgl;
      reqSync_reg <= reqMeta_reg;
      reqSeen_reg <= reqSeen_next;
      ack_reg     <= ack_next;
      rd_reg      <= rd_next;
      state_reg   <= state_next;
      src_reg     <= src_next;
      load_reg    <= load_next;
      space_reg   <= space_next;
      buf_reg     <= buf_next;
      sect_reg    <= sect_next;
      left_reg    <= left_next;
      cmd_reg     <= cmd_next;
      cmdv_reg    <= cmdv_next;
      stat_reg    <= stat_next;
      rpl_reg     <= rpl_next;
      icfg_reg    <= icfg_next;
      iflag_reg   <= iflag_next;
      vcfg_reg    <= vcfg_next;
      pcfg_reg    <= pcfg_next;
    end
  end

  assign cmd              = cmd_reg;
  assign cmdValid         = cmdv_reg;
  assign overlaySpace     = space_reg;
  assign bufActive        = buf_reg;
  assign resetPulseLength = rpl_reg;
  assign interruptConfig  = icfg_reg;
  assign interruptFlags   = iflag_reg;
  assign volatileConfig   = vcfg_reg;
  assign persistentConfig = pcfg_reg;
  assign statusValue      = stat_reg;

endmodule

// >>> hw/fcs_link.sv
// link-clock side: captures one bus cycle and hands it to the core clock
`timescale 1ns/10ps
module fcs_link
  import fcs_pkg::*;
(
  input  wire logic               linkClk,
  input  wire logic               linkReset_n,
  input  wire logic               cycleValid,
  input  wire fcs_pkg::fcs_cycle_t cycleIn,
  output logic                    cycleReady,
  output logic [15:0]             rdData,
  output logic                    rdValid,
  output fcs_pkg::fcs_cycle_t     heldCycle,
  output logic                    reqTgl,
  input  wire logic               ackTgl,
  input  wire logic [15:0]        coreRdData
);

  fcs_cycle_t  held_reg, held_next;
  logic        req_reg, req_next;
  logic        ackMeta_reg, ackSync_reg, ackSeen_reg, ackSeen_next;
  logic [15:0] rd_reg, rd_next;
  logic        rdv_reg, rdv_next;
  logic        pending;
  logic        ackEvent;

  assign pending  = req_reg != ackSeen_reg;
  assign ackEvent = ackSync_reg != ackSeen_reg;

  always_comb
  begin
    held_next    = held_reg;
    req_next     = req_reg;
    ackSeen_next = ackSeen_reg;
    rd_next      = rd_reg;
    rdv_next     = 1'b0;
    if (ackEvent)
    begin
      ackSeen_next = ackSync_reg;
      // core data is stable until the next request, so sampling here is safe
      rd_next      = coreRdData;
      rdv_next     = !held_reg.write;
    end
    else if (cycleValid && !pending)
    begin
      held_next = cycleIn;
      req_next  = !req_reg;
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      held_reg    <= '0;
      req_reg     <= 1'b0;
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      rd_reg      <= 16'h0000;
      rdv_reg     <= 1'b0;
    end
    else
    begin
      held_reg    <= held_next;
      req_reg     <= req_next;
      ackMeta_reg <= ackTgl;
      ackSync_reg <= ackMeta_reg;
      ackSeen_reg <= ackSeen_next;
      rd_reg      <= rd_next;
      rdv_reg     <= rdv_next;
    end
  end

  assign cycleReady = !pending;
  assign rdData     = rd_reg;
  assign rdValid    = rdv_reg;
  assign heldCycle  = held_reg;
  assign reqTgl     = req_reg;

endmodule

// >>> hw/fcs_pkg.sv
// shared constants and types for the flash command sequence decoder
package fcs_pkg;

  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 16;
  localparam int SECT_LSB = 17;
  localparam int WC_W     = 9;

  // command addresses, low twelve bits of the word address
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;

  // command data bytes
  localparam logic [7:0] OPC_UNLOCK1    = 8'hAA;
  localparam logic [7:0] OPC_UNLOCK2    = 8'h55;
  localparam logic [7:0] OPC_RESET      = 8'hF0;
  localparam logic [7:0] OPC_RESET_ALT  = 8'hFF;
  localparam logic [7:0] OPC_STAT_READ  = 8'h70;
  localparam logic [7:0] OPC_STAT_CLEAR = 8'h71;
  localparam logic [7:0] OPC_RPL_LOAD   = 8'h34;
  localparam logic [7:0] OPC_RPL_READ   = 8'h3C;
  localparam logic [7:0] OPC_ICFG_LOAD  = 8'h36;
  localparam logic [7:0] OPC_ICFG_READ  = 8'hC4;
  localparam logic [7:0] OPC_IFLAG_LOAD = 8'h37;
  localparam logic [7:0] OPC_IFLAG_READ = 8'hC5;
  localparam logic [7:0] OPC_VCFG_LOAD  = 8'h38;
  localparam logic [7:0] OPC_VCFG_READ  = 8'hC7;
  localparam logic [7:0] OPC_PCFG_PROG  = 8'h39;
  localparam logic [7:0] OPC_PCFG_READ  = 8'hC6;
  localparam logic [7:0] OPC_PCFG_ERASE = 8'hC8;
  localparam logic [7:0] OPC_BUF_WRITE  = 8'h25;
  localparam logic [7:0] OPC_BUF_COMMIT = 8'h29;
  localparam logic [7:0] OPC_WORD_PROG  = 8'hA0;
  localparam logic [7:0] OPC_ERASE_SET  = 8'h80;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'h10;
  localparam logic [7:0] OPC_SECT_ERASE = 8'h30;
  localparam logic [7:0] OPC_DEEP_PD    = 8'hB9;
  localparam logic [7:0] OPC_BLANK_CHK  = 8'h33;
  localparam logic [7:0] OPC_EVAL_ERASE = 8'hD0;
  localparam logic [7:0] OPC_ERASE_SUSP = 8'hB0;
  localparam logic [7:0] OPC_ERASE_RES  = 8'h30;
  localparam logic [7:0] OPC_PROG_SUSP  = 8'h51;
  localparam logic [7:0] OPC_PROG_RES   = 8'h50;
  localparam logic [7:0] OPC_ID_ENTRY   = 8'h90;
  localparam logic [7:0] OPC_OTP_ENTRY  = 8'h88;
  localparam logic [7:0] OPC_QUERY_ENT  = 8'h98;

  // values after reset, and the persistent-config value after an erase
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [15:0] RST_RPL    = 16'h0000;
  localparam logic [15:0] RST_ICFG   = 16'h0000;
  localparam logic [15:0] RST_IFLAG  = 16'h0000;
  localparam logic [15:0] RST_VCFG   = 16'h0000;
  localparam logic [15:0] RST_PCFG   = 16'hFFFF;
  localparam logic [15:0] ERASED_PCFG = 16'hFFFF;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cycle_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_WORD_PROG, OP_BUF_LOAD, OP_BUF_COMMIT, OP_BUF_ABORT, OP_CHIP_ERASE,
    OP_SECT_ERASE, OP_DEEP_PD, OP_BLANK_CHK, OP_EVAL_ERASE, OP_ERASE_SUSP, OP_ERASE_RES,
    OP_PROG_SUSP, OP_PROG_RES, OP_PCFG_PROG, OP_PCFG_ERASE
  } fcs_op_t;

  typedef struct packed {
    fcs_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cmd_t;

  typedef enum logic [1:0] {SPC_ARRAY, SPC_ID, SPC_OTP, SPC_QUERY} fcs_space_t;

endpackage

// >>> test/fcs_host_model.sv
// host controller model: one bus cycle at a time on a gated link clock
`timescale 1ns/10ps
module fcs_host_model
  import fcs_pkg::*;
(
  input  wire logic           linkClk,
  input  wire logic           cycleReady,
  input  wire logic           rdValid,
  input  wire logic [15:0]    rdData,
  output logic                linkRun,
  output logic                cycleValid,
  output fcs_pkg::fcs_cycle_t cycleIn
);
  int nHang = 0;

  initial
  begin
    linkRun    = 1'b0;
    cycleValid = 1'b0;
    cycleIn    = '0;
  end

  // gap idles first, as a slow controller would
  task automatic busCycle(input logic wr, input logic [23:0] a, input logic [15:0] d, input int gap,
                          output logic [15:0] rd);
    int n;
    n       = 0;
    linkRun = 1'b1;
    repeat (gap + 1) @(posedge linkClk);
    cycleValid <= 1'b1;
    cycleIn    <= '{write: wr, addr: a, data: d};
    do @(posedge linkClk); while (cycleReady !== 1'b1);
    cycleValid <= 1'b0;
    // released lines must not look like the last cycle
    cycleIn    <= ~cycleIn;
    do
    begin
      @(posedge linkClk);
      n++;
    end
    while (cycleReady !== 1'b1 && n < 500);
    if (cycleReady !== 1'b1 || (!wr && rdValid !== 1'b1))
      nHang++;
    rd = rdData;
    repeat (2) @(posedge linkClk);
    linkRun = 1'b0;
  endtask
endmodule

// >>> test/fcs_sva.sv
// assertion checker on the decoder top-level ports
`timescale 1ns/10ps
module fcs_sva
  import fcs_pkg::*;
(
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                linkClk,
  input wire logic                linkReset_n,
  input wire logic                cycleValid,
  input wire fcs_pkg::fcs_cycle_t cycleIn,
  input wire logic                cycleReady,
  input wire logic [15:0]         rdData,
  input wire logic                rdValid,
  input wire logic [15:0]         statusSet,
  input wire logic                cmdValid,
  input wire logic [15:0]         statusValue
);
  logic lastWr_reg;
  logic lastWr_next;

  // remembers whether the cycle in flight was a write
  always_comb lastWr_next = !linkReset_n ? 1'b0 : (cycleValid && cycleReady) ? cycleIn.write : lastWr_reg;
  always_ff @(posedge linkClk) lastWr_reg <= lastWr_next;

  sequence s_take;
    cycleValid && cycleReady;
  endsequence

  sequence s_answer;
    rdValid ##1 !rdValid;
  endsequence

  a_take_drop: assert property (@(posedge linkClk) disable iff (!linkReset_n) s_take |=> !cycleReady)
    else $error("cycle ready stayed high after a take");
  a_ready_hold: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    cycleReady && !cycleValid |=> cycleReady) else $error("cycle ready dropped with no request");
  a_ready_return: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    s_take |-> ##[2:200] cycleReady) else $error("cycle never completed");
  a_answer_pulse: assert property (@(posedge linkClk) disable iff (!linkReset_n) rdValid |-> s_answer)
    else $error("read answer longer than one cycle");
  a_answer_ready: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    rdValid |-> $rose(cycleReady)) else $error("read answer not with ready return");
  a_answer_read: assert property (@(posedge linkClk) disable iff (!linkReset_n) rdValid |-> !lastWr_reg)
    else $error("read answer after a write cycle");
  a_data_hold: assert property (@(posedge linkClk) disable iff (!linkReset_n) $changed(rdData) |-> rdValid)
    else $error("read data moved without an answer");
  a_cmd_pulse: assert property (@(posedge clk) disable iff (!reset_n) cmdValid |=> !cmdValid)
    else $error("command valid longer than one cycle");
  a_status_sticky: assert property (@(posedge clk) disable iff (!reset_n) statusSet != 16'h0000 |=>
    (statusValue & $past(statusSet)) == $past(statusSet)) else $error("status bits not set");
endmodule

bind fcs_decoder fcs_sva fcs_sva_inst (.clk, .reset_n, .linkClk, .linkReset_n, .cycleValid, .cycleIn, .cycleReady,
  .rdData, .rdValid, .statusSet, .cmdValid, .statusValue);

// >>> test/tb_flash_command_sequence_decoder.sv
// self-checking bench for the flash command sequence decoder
`timescale 1ns/10ps
module tb_flash_command_sequence_decoder;
  import fcs_pkg::*;
  localparam logic [23:0] A555     = {12'h000, ADDR_UNLOCK1};
  localparam logic [23:0] A2AA     = {12'h000, ADDR_UNLOCK2};
  localparam logic [7:0]  LOADS[5] = '{OPC_RPL_LOAD, OPC_ICFG_LOAD, OPC_IFLAG_LOAD, OPC_VCFG_LOAD, OPC_PCFG_PROG};
  localparam logic [7:0]  READS[5] = '{OPC_RPL_READ, OPC_ICFG_READ, OPC_IFLAG_READ, OPC_VCFG_READ, OPC_PCFG_READ};
  localparam logic [7:0]  ONE[6]   = '{OPC_BLANK_CHK, OPC_EVAL_ERASE, OPC_ERASE_SUSP, OPC_ERASE_RES, OPC_PROG_SUSP,
                                       OPC_PROG_RES};
  localparam fcs_op_t     ONEOP[6] = '{OP_BLANK_CHK, OP_EVAL_ERASE, OP_ERASE_SUSP, OP_ERASE_RES, OP_PROG_SUSP,
                                       OP_PROG_RES};
  localparam logic [7:0]  ENTRY[3] = '{OPC_ID_ENTRY, OPC_OTP_ENTRY, OPC_QUERY_ENT};
  logic        clk, reset_n, linkClk, linkReset_n, linkRun, cycleValid, cycleReady, rdValid, cmdValid, bufActive;
  logic [15:0] rdData, arrayRdData, statusSet, resetPulseLength, interruptConfig, interruptFlags;
  logic [15:0] volatileConfig, persistentConfig, statusValue, rd, v, rplExp;
  logic [23:0] sa;
  fcs_cycle_t  cycleIn;
  fcs_cmd_t    cmd, lastCmd;
  fcs_space_t  overlaySpace;
  int          n_mismatch, n_tests, nCmd, c0, k;

  fcs_decoder fcs_decoder_inst (.clk, .reset_n, .linkClk, .linkReset_n, .cycleValid, .cycleIn, .cycleReady, .rdData,
    .rdValid, .arrayRdData, .statusSet, .cmd, .cmdValid, .overlaySpace, .bufActive, .resetPulseLength,
    .interruptConfig, .interruptFlags, .volatileConfig, .persistentConfig, .statusValue);
  fcs_host_model fcs_host_model_inst (.linkClk, .cycleReady, .rdValid, .rdData, .linkRun, .cycleValid, .cycleIn);

  always #50 clk = ~clk;
  // link clock runs only in frames and in reset; odd offset keeps it off the core edges
  initial
  begin
    linkClk = 1'b0;
    #1.7;
    forever #6 linkClk = (linkRun || !linkReset_n) ? ~linkClk : 1'b0;
  end

  always @(posedge clk)
    if (cmdValid === 1'b1)
    begin
      lastCmd <= cmd;
      nCmd    <= nCmd + 1;
    end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] regOut(input int i);
    case (i)
      0: return resetPulseLength;
      1: return interruptConfig;
      2: return interruptFlags;
      3: return volatileConfig;
      default: return persistentConfig;
    endcase
  endfunction

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    fcs_host_model_inst.busCycle(1'b1, a, d, $urandom_range(3), rd);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rdc(input logic [23:0] a);
    fcs_host_model_inst.busCycle(1'b0, a, 16'h0000, $urandom_range(3), rd);
  endtask

  task automatic unlock;
    wr(A555, 16'(OPC_UNLOCK1));
    wr(A2AA, 16'(OPC_UNLOCK2));
  endtask

  task automatic doReset;
    @(posedge clk);
    reset_n     <= 1'b0;
    linkReset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n     <= 1'b1;
    linkReset_n <= 1'b1;
    arrayRdData <= 16'($urandom());
    @(posedge clk);
    #1;
    check("persistentConfig", RST_PCFG, persistentConfig);
    check("volatileConfig", RST_VCFG, volatileConfig);
    check("overlaySpace", 16'h0000, 16'(overlaySpace));
    $display("reset test done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    clk         = 1'b0;
    reset_n     = 1'b0;
    linkReset_n = 1'b0;
    arrayRdData = 16'h0000;
    statusSet   = 16'h0000;
    lastCmd     = '0;
    n_mismatch  = 0;
    n_tests     = 0;
    nCmd        = 0;
    void'($urandom(32'hf6b2ab26));
    doReset();
    for (int i = 0; i < 5; i++)
    begin
      // low bit set keeps the data byte off the reset opcode
      v = 16'($urandom()) | 16'h0001;
      if (i == 0)
        rplExp = v;
      unlock();
      wr(A555, 16'(LOADS[i]));
      wr(24'($urandom()), v);
      check("loaded register", v, regOut(i));
      unlock();
      wr(A555, 16'(READS[i]));
      rdc(24'($urandom()));
      check("register read", v, rd);
      rdc(24'($urandom()));
      check("array read", arrayRdData, rd);
    end
    unlock();
    wr(A555, 16'(OPC_RPL_LOAD));
    wr(24'($urandom()), 16'(OPC_RESET));
    wr(24'($urandom()), 16'h5A5B);
    check("aborted timer load", rplExp, resetPulseLength);
    unlock();
    wr(A555, 16'(OPC_PCFG_ERASE));
    check("persistent erased", ERASED_PCFG, persistentConfig);
    check("erase op", 16'(OP_PCFG_ERASE), 16'(lastCmd.op));
    $display("register test done");
    @(posedge clk);
    v = 16'($urandom()) | 16'h0001;
    statusSet <= v;
    @(posedge clk);
    statusSet <= 16'h0000;
    wr(A555, 16'(OPC_STAT_READ));
    rdc(24'($urandom()));
    check("status read", v, rd);
    wr(A555, 16'(OPC_STAT_CLEAR));
    check("status cleared", 16'h0000, statusValue);
    $display("status test done");
    for (int j = 0; j < 2; j++)
    begin
      sa = 24'($urandom());
      k  = j ? 3 : $urandom_range(3);
      unlock();
      wr(sa, 16'(OPC_BUF_WRITE));
      wr(sa, 16'(k));
      c0 = nCmd;
      for (int m = 0; m < (j ? 1 : k + 1); m++)
        wr({sa[23:17], 17'($urandom())}, 16'($urandom()) | 16'h0001);
      check("buffer loads", 16'(j ? 1 : k + 1), 16'(nCmd - c0));
      check("buffer active", 16'h0001, 16'(bufActive));
      if (j == 0)
        wr(sa, 16'(OPC_BUF_COMMIT));
      else
      begin
        unlock();
        wr(A555, 16'(OPC_RESET));
      end
      check("buffer end op", 16'(j ? OP_BUF_ABORT : OP_BUF_COMMIT), 16'(lastCmd.op));
      check("buffer idle", 16'h0000, 16'(bufActive));
    end
    $display("buffer test done");
    unlock();
    wr(A555, 16'(OPC_WORD_PROG));
    sa = 24'($urandom());
    v  = 16'($urandom()) | 16'h0001;
    wr(sa, v);
    check("word program op", 16'(OP_WORD_PROG), 16'(lastCmd.op));
    check("word program data", v, lastCmd.data);
    check("word program addr", sa[15:0], lastCmd.addr[15:0]);
    for (int e = 0; e < 2; e++)
    begin
      unlock();
      wr(A555, 16'(OPC_ERASE_SET));
      unlock();
      wr(e ? sa : A555, 16'(e ? OPC_SECT_ERASE : OPC_CHIP_ERASE));
      check("erase op", 16'(e ? OP_SECT_ERASE : OP_CHIP_ERASE), 16'(lastCmd.op));
    end
    unlock();
    wr(24'($urandom()), 16'(OPC_DEEP_PD));
    check("power-down op", 16'(OP_DEEP_PD), 16'(lastCmd.op));
    for (int s = 0; s < 6; s++)
    begin
      wr(24'($urandom()), 16'(ONE[s]));
      check("single-cycle op", 16'(ONEOP[s]), 16'(lastCmd.op));
    end
    $display("opcode test done");
    for (int o = 0; o < 3; o++)
    begin
      if (o < 2)
        unlock();
      wr(A555, 16'(ENTRY[o]));
      check("overlay entered", 16'(o + 1), 16'(overlaySpace));
      rdc(24'($urandom()));
      check("overlay read", arrayRdData, rd);
      wr(24'($urandom()), 16'(o == 0 ? OPC_RESET_ALT : OPC_RESET));
      check("overlay left", 16'h0000, 16'(overlaySpace));
    end
    $display("overlay test done");
    unlock();
    wr(A555, 16'(OPC_VCFG_LOAD));
    wr(24'($urandom()), 16'hA5A5);
    doReset();
    check("host hangs", 16'h0000, 16'(fcs_host_model_inst.nHang));
    conclude();
  end
endmodule
